// ### sbt_defs.svh
// Constants for the scan bus transceiver
`ifndef SBT_DEFS_SVH
`define SBT_DEFS_SVH

`define SBT_HALF_W 9
`define SBT_BUS_W 18
`define SBT_IR_W 8
`define SBT_BSR_W 48
`define SBT_BCR_W 3
`define SBT_ID_W 32
`define SBT_SYNC_W 51

// Instruction opcodes, even parity
`define SBT_OP_IDCODE 8'h81
`define SBT_OP_BYPASS 8'hff
`define SBT_OP_EXTEST 8'h00
`define SBT_OP_SAMPLE 8'h82
`define SBT_OP_RUNT 8'h09
`define SBT_OP_BCRSCAN 8'h8e
`define SBT_IR_CAPT 8'h81

// Boundary control operations
`define SBT_BCR_PSA 3'h2
`define SBT_BCR_PSEUDO_RANDOM_PATTERN_GEN 3'h3
`define SBT_BCR_RST 3'h2

// Arbitrary neutral identification value
`define SBT_IDCODE_VAL 32'h00000001

// Boundary chain layout
`define SBT_BSR_A_LO 0
`define SBT_BSR_B_LO 18
`define SBT_BSR_OEN_LO 36
`define SBT_BSR_LE_LO 40
`define SBT_BSR_EN_LO 44
`define SBT_BSR_EN_RST 4'hf
`define SBT_DATA_CELLS 36

`endif

// ### sbt_pkg.sv
// Types for the scan bus transceiver
package sbt_pkg;

	typedef enum logic [3:0] {
		SBT_TLR, SBT_RTI, SBT_SEL_DR, SBT_CAP_DR, SBT_SHIFT_DR, SBT_EX1_DR,
		SBT_PAUSE_DR, SBT_EX2_DR, SBT_UPD_DR, SBT_SEL_IR, SBT_CAP_IR,
		SBT_SHIFT_IR, SBT_EX1_IR, SBT_PAUSE_IR, SBT_EX2_IR, SBT_UPD_IR
	} sbt_tap_e;

	typedef enum logic [1:0] {
		SBT_DR_BYP, SBT_DR_BSR, SBT_DR_BCR, SBT_DR_ID
	} sbt_dr_e;

	typedef logic [8:0] sbt_half_t;

endpackage

// ### sbt_half_if.sv
// Link between the top and one transceiver half
`timescale 1ns/100ps
interface sbt_half_if;
	logic [1:0][8:0] src;
	logic [1:0][8:0] dst;
	logic [1:0] le;
	logic [1:0] clk_rise;
	logic freeze;
	modport xcvr (input src, input le, input clk_rise, input freeze,
		output dst);
	modport ctrl (output src, output le, output clk_rise, output freeze,
		input dst);
endinterface

// ### sbt_half.sv
// One 9-bit half: latch and flop path for both directions
`timescale 1ns/100ps
`include "sbt_defs.svh"
module sbt_half (
	input wire logic ref_clk,
	input wire logic rstn,
	sbt_half_if.xcvr hif
);

	// ======================================
	// Per direction: 0 is A to B, 1 is B to A
	genvar d;
	generate
		for (d = 0; d < 2; d++) begin : g_dir
			sbt_pkg::sbt_half_t mem_q [2];
			sbt_pkg::sbt_half_t mem_d [2];
			sbt_pkg::sbt_half_t hold_q;
			sbt_pkg::sbt_half_t hold_d;
			logic wp_q, wp_d, rp_q, rp_d;
			logic [1:0] cnt_q, cnt_d;
			logic in_valid, in_ready, out_valid, out_ready;

			assign in_valid = ~hif.le[d] & hif.clk_rise[d];
			assign in_ready = (cnt_q != 2'h2);
			assign out_valid = (cnt_q != 2'h0);
			assign out_ready = ~hif.freeze;
			assign hif.dst[d] = hold_q;

			always_comb begin
				mem_d = mem_q;
				wp_d = wp_q;
				rp_d = rp_q;
				cnt_d = cnt_q;
				hold_d = hold_q;
				if (hif.le[d]) begin
					// Transparent, buffer flushed
					hold_d = hif.src[d];
					wp_d = 1'b0;
					rp_d = 1'b0;
					cnt_d = 2'h0;
				end else begin
					if (in_valid && in_ready) begin
						mem_d[wp_q] = hif.src[d];
						wp_d = ~wp_q;
					end
					if (out_valid && out_ready) begin
						hold_d = mem_q[rp_q];
						rp_d = ~rp_q;
					end
					// Otherwise hold_q keeps the stored value
					cnt_d = cnt_q + 2'((in_valid && in_ready) ? 1 : 0)
						- 2'((out_valid && out_ready) ? 1 : 0);
				end
			end

			always_ff @(posedge ref_clk or negedge rstn) begin
				if (!rstn) begin
					mem_q[0] <= 9'h000;
					mem_q[1] <= 9'h000;
					wp_q <= 1'b0;
					rp_q <= 1'b0;
					cnt_q <= 2'h0;
					hold_q <= 9'h000;
				end else begin
					mem_q <= mem_d;
					wp_q <= wp_d;
					rp_q <= rp_d;
					cnt_q <= cnt_d;
					hold_q <= hold_d;
				end
			end
		end
	endgenerate

endmodule

// ### sbt_top.sv
// Scan bus transceiver top: pins, sampling, TAP and boundary scan
`timescale 1ns/100ps
`include "sbt_defs.svh"
module sbt_top (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic [17:0] a_in,
	output logic [17:0] a_out,
	output logic [17:0] a_oe,
	input wire logic [17:0] b_in,
	output logic [17:0] b_out,
	output logic [17:0] b_oe,
	input wire logic [1:0] a_to_b_output_enable_n,
	input wire logic [1:0] b_to_a_output_enable_n,
	input wire logic [1:0] a_to_b_latch_enable,
	input wire logic [1:0] b_to_a_latch_enable,
	input wire logic [1:0] a_to_b_clock,
	input wire logic [1:0] b_to_a_clock,
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	output logic tdo,
	output logic tdo_oe
);

	// ======================================
	// Two-stage sampling of every pin
	logic [50:0] sync1_q, sync2_q;
	logic [5:0] edge_q;
	logic [17:0] a_s, b_s;
	logic [1:0] a_to_b_output_enable_n_n_s, b_to_a_output_enable_n_n_s, a_to_b_latch_enable_s, b_to_a_latch_enable_s, ckab_s, ckba_s;
	logic tck_s, tms_s, tdi_s, tck_rise, tck_fall;
	logic [1:0] ckab_rise, ckba_rise;

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			sync1_q <= 51'h0;
			sync2_q <= 51'h0;
			edge_q <= 6'h00;
		end else begin
			sync1_q <= {a_in, b_in, a_to_b_output_enable_n,
				b_to_a_output_enable_n, a_to_b_latch_enable,
				b_to_a_latch_enable, a_to_b_clock, b_to_a_clock,
				tck, tms, tdi};
			sync2_q <= sync1_q;
			edge_q <= {ckab_s, ckba_s, tck_s, 1'b0};
		end
	end

	assign {a_s, b_s, a_to_b_output_enable_n_n_s, b_to_a_output_enable_n_n_s, a_to_b_latch_enable_s, b_to_a_latch_enable_s, ckab_s, ckba_s,
		tck_s, tms_s, tdi_s} = sync2_q;
	assign tck_rise = tck_s & ~edge_q[1];
	assign tck_fall = ~tck_s & edge_q[1];
	assign ckab_rise = ckab_s & ~edge_q[5:4];
	assign ckba_rise = ckba_s & ~edge_q[3:2];

	// ======================================
	// Transceiver halves
	logic test_mode;
	logic [17:0] xb, xa;

	genvar h;
	generate
		for (h = 0; h < 2; h++) begin : g_half
			sbt_half_if hif ();
			assign hif.src[0] = a_s[h*9 +: 9];
			assign hif.src[1] = b_s[h*9 +: 9];
			assign hif.le = {b_to_a_latch_enable_s[h], a_to_b_latch_enable_s[h]};
			assign hif.clk_rise = {ckba_rise[h], ckab_rise[h]};
			assign hif.freeze = test_mode;
			assign xb[h*9 +: 9] = hif.dst[0];
			assign xa[h*9 +: 9] = hif.dst[1];
			sbt_half u_half (
				.ref_clk(ref_clk),
				.rstn(rstn),
				.hif(hif.xcvr)
			);
		end
	endgenerate

	// ======================================
	// TAP and test registers
	sbt_pkg::sbt_tap_e tap_q, tap_d;
	logic [7:0] ir_sh_q, ir_sh_d, ir_q, ir_d;
	logic [47:0] bsr_sh_q, bsr_sh_d, bsr_up_q, bsr_up_d;
	logic [2:0] bcr_sh_q, bcr_sh_d, bcr_q, bcr_d;
	logic byp_q, byp_d;
	logic [31:0] id_q, id_d;
	logic tdo_q, tdo_d, tdo_oe_q, tdo_oe_d;
	sbt_pkg::sbt_dr_e dr_sel;
	logic [47:0] bsr_pins;
	logic [35:0] lfsr;

	function automatic sbt_pkg::sbt_tap_e tap_next(
		input sbt_pkg::sbt_tap_e s,
		input logic m
	);
		sbt_pkg::sbt_tap_e n;
		n = s;
		case (s)
			sbt_pkg::SBT_TLR: n = m ? sbt_pkg::SBT_TLR : sbt_pkg::SBT_RTI;
			sbt_pkg::SBT_RTI: n = m ? sbt_pkg::SBT_SEL_DR : sbt_pkg::SBT_RTI;
			sbt_pkg::SBT_SEL_DR: n = m ? sbt_pkg::SBT_SEL_IR : sbt_pkg::SBT_CAP_DR;
			sbt_pkg::SBT_CAP_DR: n = m ? sbt_pkg::SBT_EX1_DR : sbt_pkg::SBT_SHIFT_DR;
			sbt_pkg::SBT_SHIFT_DR: n = m ? sbt_pkg::SBT_EX1_DR : sbt_pkg::SBT_SHIFT_DR;
			sbt_pkg::SBT_EX1_DR: n = m ? sbt_pkg::SBT_UPD_DR : sbt_pkg::SBT_PAUSE_DR;
			sbt_pkg::SBT_PAUSE_DR: n = m ? sbt_pkg::SBT_EX2_DR : sbt_pkg::SBT_PAUSE_DR;
			sbt_pkg::SBT_EX2_DR: n = m ? sbt_pkg::SBT_UPD_DR : sbt_pkg::SBT_SHIFT_DR;
			sbt_pkg::SBT_UPD_DR: n = m ? sbt_pkg::SBT_SEL_DR : sbt_pkg::SBT_RTI;
			sbt_pkg::SBT_SEL_IR: n = m ? sbt_pkg::SBT_TLR : sbt_pkg::SBT_CAP_IR;
			sbt_pkg::SBT_CAP_IR: n = m ? sbt_pkg::SBT_EX1_IR : sbt_pkg::SBT_SHIFT_IR;
			sbt_pkg::SBT_SHIFT_IR: n = m ? sbt_pkg::SBT_EX1_IR : sbt_pkg::SBT_SHIFT_IR;
			sbt_pkg::SBT_EX1_IR: n = m ? sbt_pkg::SBT_UPD_IR : sbt_pkg::SBT_PAUSE_IR;
			sbt_pkg::SBT_PAUSE_IR: n = m ? sbt_pkg::SBT_EX2_IR : sbt_pkg::SBT_PAUSE_IR;
			sbt_pkg::SBT_EX2_IR: n = m ? sbt_pkg::SBT_UPD_IR : sbt_pkg::SBT_SHIFT_IR;
			sbt_pkg::SBT_UPD_IR: n = m ? sbt_pkg::SBT_SEL_DR : sbt_pkg::SBT_RTI;
			default: n = sbt_pkg::SBT_TLR;
		endcase
		return n;
	endfunction

	// Data register chosen by the active instruction
	always_comb begin
		if (ir_q == `SBT_OP_EXTEST || ir_q == `SBT_OP_SAMPLE) begin
			dr_sel = sbt_pkg::SBT_DR_BSR;
		end else if (ir_q == `SBT_OP_BCRSCAN) begin
			dr_sel = sbt_pkg::SBT_DR_BCR;
		end else if (ir_q == `SBT_OP_IDCODE) begin
			dr_sel = sbt_pkg::SBT_DR_ID;
		end else begin
			dr_sel = sbt_pkg::SBT_DR_BYP;
		end
	end

	// Test mode only from the updated instruction
	assign test_mode = (tap_q != sbt_pkg::SBT_TLR) &&
		(ir_q == `SBT_OP_EXTEST || ir_q == `SBT_OP_RUNT);
	assign bsr_pins = {bsr_up_q[47:44], b_to_a_latch_enable_s, a_to_b_latch_enable_s, b_to_a_output_enable_n_n_s, a_to_b_output_enable_n_n_s,
		b_s, a_s};
	assign lfsr = {bsr_sh_q[34:0], bsr_sh_q[35] ^ bsr_sh_q[24]};

	always_comb begin
		tap_d = tap_q;
		ir_sh_d = ir_sh_q;
		ir_d = ir_q;
		bsr_sh_d = bsr_sh_q;
		bsr_up_d = bsr_up_q;
		bcr_sh_d = bcr_sh_q;
		bcr_d = bcr_q;
		byp_d = byp_q;
		id_d = id_q;
		tdo_d = tdo_q;
		tdo_oe_d = tdo_oe_q;
		if (tck_rise) begin
			tap_d = tap_next(tap_q, tms_s);
			case (tap_q)
				sbt_pkg::SBT_CAP_DR: begin
					bsr_sh_d = bsr_pins;
					bcr_sh_d = bcr_q;
					byp_d = 1'b0;
					id_d = `SBT_IDCODE_VAL;
				end
				sbt_pkg::SBT_SHIFT_DR: begin
					case (dr_sel)
						sbt_pkg::SBT_DR_BSR: bsr_sh_d = {tdi_s, bsr_sh_q[47:1]};
						sbt_pkg::SBT_DR_BCR: bcr_sh_d = {tdi_s, bcr_sh_q[2:1]};
						sbt_pkg::SBT_DR_ID: id_d = {tdi_s, id_q[31:1]};
						default: byp_d = tdi_s;
					endcase
				end
				sbt_pkg::SBT_CAP_IR: ir_sh_d = `SBT_IR_CAPT;
				sbt_pkg::SBT_SHIFT_IR: ir_sh_d = {tdi_s, ir_sh_q[7:1]};
				sbt_pkg::SBT_RTI: begin
					if (ir_q == `SBT_OP_RUNT) begin
						if (bcr_q == `SBT_BCR_PSA) begin
							bsr_sh_d[35:0] = lfsr ^ bsr_pins[35:0];
						end else if (bcr_q == `SBT_BCR_PSEUDO_RANDOM_PATTERN_GEN) begin
							bsr_sh_d[35:0] = lfsr;
							bsr_up_d[35:0] = lfsr;
						end
					end
				end
				default: begin
				end
			endcase
		end else if (tck_fall) begin
			if (tap_q == sbt_pkg::SBT_SHIFT_IR) begin
				tdo_oe_d = 1'b1;
				tdo_d = ir_sh_q[0];
			end else if (tap_q == sbt_pkg::SBT_SHIFT_DR) begin
				tdo_oe_d = 1'b1;
				case (dr_sel)
					sbt_pkg::SBT_DR_BSR: tdo_d = bsr_sh_q[0];
					sbt_pkg::SBT_DR_BCR: tdo_d = bcr_sh_q[0];
					sbt_pkg::SBT_DR_ID: tdo_d = id_q[0];
					default: tdo_d = byp_q;
				endcase
			end else begin
				tdo_oe_d = 1'b0;
			end
			if (tap_q == sbt_pkg::SBT_UPD_IR) begin
				ir_d = ir_sh_q;
			end else if (tap_q == sbt_pkg::SBT_UPD_DR) begin
				if (dr_sel == sbt_pkg::SBT_DR_BSR) begin
					bsr_up_d = bsr_sh_q;
				end else if (dr_sel == sbt_pkg::SBT_DR_BCR) begin
					bcr_d = bcr_sh_q;
				end
			end
		end
		if (tap_q == sbt_pkg::SBT_TLR) begin
			ir_d = `SBT_OP_IDCODE;
			bsr_up_d[47:44] = `SBT_BSR_EN_RST;
			bcr_d = `SBT_BCR_RST;
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			tap_q <= sbt_pkg::SBT_TLR;
			ir_sh_q <= `SBT_IR_CAPT;
			ir_q <= `SBT_OP_IDCODE;
			bsr_sh_q <= 48'h0;
			bsr_up_q <= {`SBT_BSR_EN_RST, 44'h0};
			bcr_sh_q <= `SBT_BCR_RST;
			bcr_q <= `SBT_BCR_RST;
			byp_q <= 1'b0;
			id_q <= `SBT_IDCODE_VAL;
			tdo_q <= 1'b0;
			tdo_oe_q <= 1'b0;
		end else begin
			tap_q <= tap_d;
			ir_sh_q <= ir_sh_d;
			ir_q <= ir_d;
			bsr_sh_q <= bsr_sh_d;
			bsr_up_q <= bsr_up_d;
			bcr_sh_q <= bcr_sh_d;
			bcr_q <= bcr_d;
			byp_q <= byp_d;
			id_q <= id_d;
			tdo_q <= tdo_d;
			tdo_oe_q <= tdo_oe_d;
		end
	end

	assign tdo = tdo_q;
	assign tdo_oe = tdo_oe_q;

	// ======================================
	// Pin drivers
	logic [17:0] a_out_q, a_out_d, a_oe_q, a_oe_d;
	logic [17:0] b_out_q, b_out_d, b_oe_q, b_oe_d;

	always_comb begin
		if (test_mode) begin
			// Boundary cells own the pins
			a_out_d = bsr_up_q[17:0];
			b_out_d = bsr_up_q[35:18];
			b_oe_d = {{9{~bsr_up_q[46]}}, {9{~bsr_up_q[44]}}};
			a_oe_d = {{9{~bsr_up_q[47]}}, {9{~bsr_up_q[45]}}};
		end else begin
			// Functional path, untouched by scan activity
			a_out_d = xa;
			b_out_d = xb;
			b_oe_d = {{9{~a_to_b_output_enable_n_n_s[1]}}, {9{~a_to_b_output_enable_n_n_s[0]}}};
			a_oe_d = {{9{~b_to_a_output_enable_n_n_s[1]}}, {9{~b_to_a_output_enable_n_n_s[0]}}};
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			a_out_q <= 18'h0;
			a_oe_q <= 18'h0;
			b_out_q <= 18'h0;
			b_oe_q <= 18'h0;
		end else begin
			a_out_q <= a_out_d;
			a_oe_q <= a_oe_d;
			b_out_q <= b_out_d;
			b_oe_q <= b_oe_d;
		end
	end

	assign a_out = a_out_q;
	assign a_oe = a_oe_q;
	assign b_out = b_out_q;
	assign b_oe = b_oe_q;

endmodule

// ### sbt_chk_sva.sv
// Port checker for the scan bus transceiver
`timescale 1ns/100ps
module sbt_chk (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic [17:0] a_in,
	input wire logic [17:0] a_out,
	input wire logic [17:0] a_oe,
	input wire logic [17:0] b_in,
	input wire logic [17:0] b_out,
	input wire logic [17:0] b_oe,
	input wire logic [1:0] a_to_b_output_enable_n,
	input wire logic [1:0] b_to_a_output_enable_n,
	input wire logic [1:0] a_to_b_latch_enable,
	input wire logic [1:0] b_to_a_latch_enable,
	input wire logic [1:0] a_to_b_clock,
	input wire logic [1:0] b_to_a_clock,
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	input wire logic tdo,
	input wire logic tdo_oe
);
	default clocking dcb @(posedge ref_clk);
	endclocking
	default disable iff (!rstn);

	// ====================
	// Count of test clock rises with mode select high
	logic tck_q, tck_d;
	logic [2:0] cnt_q, cnt_d;
	always_comb begin
		tck_d = tck;
		cnt_d = cnt_q;
		if (tck && !tck_q && !tms) begin
			cnt_d = 3'h0;
		end else if (tck && !tck_q && cnt_q != 3'h7) begin
			cnt_d = cnt_q + 3'h1;
		end
	end
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			tck_q <= 1'b0;
			cnt_q <= 3'h0;
		end else begin
			tck_q <= tck_d;
			cnt_q <= cnt_d;
		end
	end

	// ====================
	// Assertions
	chk_trans_ab: assert property (
		(a_to_b_latch_enable[0] && !a_to_b_output_enable_n[0]
		&& $stable(a_in[8:0]))[*6] |-> b_out[8:0] == a_in[8:0])
		else $error("transparent A to B path wrong");
	chk_trans_ba: assert property (
		(b_to_a_latch_enable[1] && !b_to_a_output_enable_n[1]
		&& $stable(b_in[17:9]))[*6] |-> a_out[17:9] == b_in[17:9])
		else $error("transparent B to A path wrong");
	chk_hold_ab: assert property (
		(!a_to_b_latch_enable[0] && !a_to_b_output_enable_n[0]
		&& $stable(a_to_b_clock[0]))[*7] |-> $stable(b_out[8:0]))
		else $error("latched B output moved");
	chk_clk_cap: assert property (
		($rose(a_to_b_clock[1]) && !a_to_b_output_enable_n[1])
		##0 (!a_to_b_latch_enable[1] && $stable(a_in[17:9]))[*7]
		|-> b_out[17:9] == a_in[17:9])
		else $error("clocked capture wrong");
	chk_oe_off_ab: assert property (
		a_to_b_output_enable_n[1] [*4] |-> b_oe[17:9] == 9'h000)
		else $error("B half driven while disabled");
	chk_oe_off_ba: assert property (
		b_to_a_output_enable_n[0] [*4] |-> a_oe[8:0] == 9'h000)
		else $error("A half driven while disabled");
	chk_tdo_fall: assert property (
		($changed(tdo) || $rose(tdo_oe)) |-> !tck)
		else $error("test output moved while test clock high");
	chk_tap_reset: assert property (
		cnt_q >= 3'h5 |-> !tdo_oe)
		else $error("test output driven after reset sequence");
	cover property ($rose(tdo_oe));
	cover property ($rose(a_to_b_clock[1]) && !a_to_b_latch_enable[1]);
	cover property ($fell(a_oe[17]));
endmodule

bind sbt_top sbt_chk u_sbt_chk (
	.ref_clk, .rstn, .a_in, .a_out, .a_oe, .b_in, .b_out, .b_oe,
	.a_to_b_output_enable_n, .b_to_a_output_enable_n,
	.a_to_b_latch_enable, .b_to_a_latch_enable,
	.a_to_b_clock, .b_to_a_clock, .tck, .tms, .tdi, .tdo, .tdo_oe
);

// ### sbt_tap_drv.sv
// Test controller model driving the test access port
`timescale 1ns/100ps
module sbt_tap_drv (
	input wire logic ref_clk,
	output logic tck,
	output logic tms,
	output logic tdi,
	input wire logic tdo,
	input wire logic tdo_oe
);
	logic tdo_last;
	logic tdo_line;
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b1;
		tdo_last = 1'b0;
	end
	// Released line reads as the inverse of its last level
	always @(posedge ref_clk) begin
		if (tdo_oe) begin
			tdo_last <= tdo;
		end
	end
	assign tdo_line = tdo_oe ? tdo : ~tdo_last;

	// ====================
	// One test clock period; clock stands low between calls
	task automatic step(input logic m, input logic d, output logic o);
		tms = m;
		tdi = d;
		repeat (16) @(negedge ref_clk);
		o = tdo_line;
		tck = 1'b1;
		repeat (16) @(negedge ref_clk);
		tck = 1'b0;
	endtask

	task automatic reset_tap();
		logic o;
		repeat (5) step(1'b1, 1'b1, o);
		step(1'b0, 1'b1, o);
	endtask

	// Scan from idle, back to idle, low bit first
	task automatic scan(input logic ir, input logic [47:0] din,
		output logic [47:0] dout);
		logic o;
		step(1'b1, 1'b0, o);
		if (ir) begin
			step(1'b1, 1'b0, o);
		end
		step(1'b0, 1'b0, o);
		step(1'b0, 1'b0, o);
		for (int i = 0; i < 48; i++) begin
			step(i == 47, din[i], dout[i]);
		end
		step(1'b1, 1'b0, o);
		step(1'b0, 1'b0, o);
	endtask
endmodule

// ### sbt_top_bench.sv
// Self-checking bench for the scan bus transceiver
`timescale 1ns/100ps
`include "sbt_defs.svh"
`define SBT_CHK(g, e) \
	begin \
		comparisons++; \
		if ((g) !== (e)) begin \
			failures++; \
			$display("[ERR] %0t got %h want %h", $time, g, e); \
		end \
	end
module sbt_top_bench;
	logic ref_clk, rstn, tck, tms, tdi, tdo, tdo_oe;
	logic [17:0] a_in, a_out, a_oe, b_in, b_out, b_oe;
	logic [17:0] drv [2];
	logic [1:0] oen [2], le [2], bclk [2];
	logic [47:0] r, dout;
	logic [8:0] v;
	int failures, comparisons, cycles;

	// Pin level from the device's enable; the bench drives wherever it is clear
	assign a_in = (a_oe & a_out) | (~a_oe & drv[0]);
	assign b_in = (b_oe & b_out) | (~b_oe & drv[1]);

	sbt_top u_sbt_top (.ref_clk(ref_clk), .rstn(rstn), .a_in(a_in),
		.a_out(a_out), .a_oe(a_oe), .b_in(b_in), .b_out(b_out),
		.b_oe(b_oe), .a_to_b_output_enable_n(oen[0]),
		.b_to_a_output_enable_n(oen[1]), .a_to_b_latch_enable(le[0]),
		.b_to_a_latch_enable(le[1]), .a_to_b_clock(bclk[0]),
		.b_to_a_clock(bclk[1]), .tck(tck), .tms(tms), .tdi(tdi),
		.tdo(tdo), .tdo_oe(tdo_oe));
	sbt_tap_drv u_sbt_tap_drv (.ref_clk(ref_clk), .tck(tck), .tms(tms),
		.tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));

	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 60000) begin
			failures++;
			summarize();
		end
	end

	task automatic summarize();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic wait_cyc(input int n);
		repeat (n) @(negedge ref_clk);
	endtask
	function automatic logic [8:0] out_half(input int d, input int h);
		return d ? a_out[h*9 +: 9] : b_out[h*9 +: 9];
	endfunction
	function automatic logic [8:0] oe_half(input int d, input int h);
		return d ? a_oe[h*9 +: 9] : b_oe[h*9 +: 9];
	endfunction

	// ====================
	// Transparent, latched, clocked and disabled on one half
	task automatic bus_test(input int d, input int h);
		logic [8:0] w;
		w = 9'($urandom);
		drv[d][h*9 +: 9] = ~w;
		le[d][h] = 1'b1;
		oen[d][h] = 1'b0;
		wait_cyc(8);
		`SBT_CHK(out_half(d, h), ~w)
		`SBT_CHK(oe_half(d, h), 9'h1ff)
		`SBT_CHK(oe_half(d, 1 - h), 9'h000)
		le[d][h] = 1'b0;
		wait_cyc(6);
		drv[d][h*9 +: 9] = w;
		wait_cyc(8);
		`SBT_CHK(out_half(d, h), ~w)
		bclk[d][h] = 1'b1;
		wait_cyc(4);
		bclk[d][h] = 1'b0;
		wait_cyc(8);
		`SBT_CHK(out_half(d, h), w)
		oen[d][h] = 1'b1;
		wait_cyc(5);
		`SBT_CHK(oe_half(d, h), 9'h000)
	endtask

	initial begin
		rstn = 1'b0;
		for (int i = 0; i < 2; i++) begin
			drv[i] = 18'h00000;
			oen[i] = 2'h3;
			le[i] = 2'h0;
			bclk[i] = 2'h0;
		end
		failures = 0;
		comparisons = 0;
		cycles = 0;
		void'($urandom(32'hd3447d20));
		wait_cyc(8);
		rstn = 1'b1;
		wait_cyc(4);
		for (int i = 0; i < 4; i++) begin
			bus_test(i / 2, i % 2);
		end
		$display("bus paths done");
		// ====================
		// Register lengths and captures
		u_sbt_tap_drv.reset_tap();
		r = 48'({$urandom(), $urandom()});
		u_sbt_tap_drv.scan(1'b0, r, dout);
		`SBT_CHK(dout[31:0], `SBT_IDCODE_VAL)
		`SBT_CHK(dout[47:32], r[15:0])
		u_sbt_tap_drv.scan(1'b1, {`SBT_OP_BYPASS, r[39:0]}, dout);
		`SBT_CHK(dout[7:0], `SBT_IR_CAPT)
		`SBT_CHK(dout[47:8], r[39:0])
		u_sbt_tap_drv.scan(1'b0, r, dout);
		`SBT_CHK(dout, {r[46:0], 1'b0})
		u_sbt_tap_drv.scan(1'b1, {`SBT_OP_BCRSCAN, r[39:0]}, dout);
		u_sbt_tap_drv.scan(1'b0, r, dout);
		`SBT_CHK(dout[2:0], `SBT_BCR_RST)
		`SBT_CHK(dout[47:3], r[44:0])
		$display("register scans done");
		// ====================
		// Sampling in normal mode
		v = 9'($urandom);
		drv[0][8:0] = v;
		le[0][0] = 1'b1;
		oen[0][0] = 1'b0;
		u_sbt_tap_drv.scan(1'b1, {`SBT_OP_SAMPLE, r[39:0]}, dout);
		u_sbt_tap_drv.scan(1'b0, r | 48'hf00000000000, dout);
		`SBT_CHK(dout[8:0], v)
		`SBT_CHK(dout[26:18], v)
		`SBT_CHK(dout[47:44], `SBT_BSR_EN_RST)
		`SBT_CHK(b_out[8:0], v)
		`SBT_CHK(b_oe[8:0], 9'h1ff)
		$display("sample done");
		// ====================
		// Test mode entry and exit
		oen[0][0] = 1'b1;
		le[0][0] = 1'b0;
		oen[1][1] = 1'b0;
		wait_cyc(8);
		`SBT_CHK(a_oe[17:9], 9'h1ff)
		u_sbt_tap_drv.scan(1'b1, {`SBT_OP_EXTEST, r[39:0]}, dout);
		`SBT_CHK(a_oe[17:9], 9'h000)
		u_sbt_tap_drv.reset_tap();
		wait_cyc(8);
		`SBT_CHK(a_oe[17:9], 9'h1ff)
		$display("test mode done");
		summarize();
	end
endmodule
